// ---- common/elc_pkg.sv ----
/*
  Constants for the expanded line configuration bank: register offsets,
  field positions, reset values and the bank pointer codes.
  Assumes a host interface front end that presents byte-wide register
  accesses as one-cycle strobes on the device clock.
*/
package elc_pkg;
  localparam int NUM_CH = 4;
  localparam logic [7:0] OFF_SINGLE_RAIL = 8'h00;
  localparam logic [7:0] OFF_LINE_CODE = 8'h01;
  localparam logic [7:0] OFF_CLK_REC_DIS = 8'h02;
  localparam logic [7:0] OFF_RX_PDN = 8'h03;
  localparam logic [7:0] OFF_TX_PDN = 8'h04;
  localparam logic [7:0] OFF_EXZ_EN = 8'h05;
  localparam logic [7:0] OFF_CV_DIS = 8'h06;
  localparam logic [7:0] OFF_EQ_EN = 8'h07;
  localparam logic [7:0] OFF_LOOP_CFG = 8'h08;
  localparam logic [7:0] OFF_ACT_CODE = 8'h09;
  localparam logic [7:0] OFF_DEACT_CODE = 8'h0a;
  localparam logic [7:0] OFF_BANK_PTR = 8'h1f;
  localparam logic [7:0] BANK_PRIMARY = 8'h00;
  localparam logic [7:0] BANK_EXPANDED = 8'haa;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  localparam logic [3:0] CLK_REC_ON_RESET = 4'hf;
  localparam logic [7:0] CODE_MASK_RESET = 8'hf8;
  localparam int LCF_DET_EN = 5;
  localparam int LCF_AUTO_EN = 4;
  localparam int LCF_ACT_LEN_LSB = 2;
  localparam int LCF_DEACT_LEN_LSB = 0;
  localparam logic [7:0] LCF_MASK = 8'h3f;
  localparam logic [7:0] CH_MASK = 8'h0f;
endpackage : elc_pkg

// ---- rtl/elc_bank.sv ----
/*
  Expanded line configuration register bank with the bank pointer.
  Reached by the host interface front end through wrEn/rdEn strobes,
  an 8-bit address and byte data, all synchronous to clk. Per-channel
  controls are decoded into the effective mode bits the line logic uses.
*/
module elc_bank
  import elc_pkg::*;
(
  input wire logic clk, // 250 MHz device clock
  input wire logic rst_n, // Async reset, active low
  input wire logic wrEn, // Host write strobe
  input wire logic rdEn, // Host read strobe
  input wire logic [7:0] addr, // Host register address
  input wire logic [7:0] wrData, // Host write data
  input wire logic [3:0] railSelectPin, // Per channel single rail request pin
  input wire logic [3:0] transmitClockPin, // Per channel transmit clock pin
  output logic [7:0] rdData, // Read data, registered
  output logic rdValid, // Read data valid pulse
  output logic expandedSel, // Expanded bank selected
  output logic [3:0] singleRailMode, // Channel runs single rail
  output logic [3:0] amiSelect, // AMI coding, else B8ZS/HDB3
  output logic [3:0] clockRecoveryOn, // Clock recovery active
  output logic [3:0] rxPowerDown, // Receiver powered down
  output logic [3:0] txPowerDown, // Transmitter powered down
  output logic [3:0] txDriverOe, // Transmit driver enable, low means high-Z
  output logic [3:0] excessZeroDetect, // Excess-zero detection active
  output logic [3:0] codeViolationDetect, // Code violation detection active
  output logic [3:0] rxEqualizerOn, // Receive equalizer enabled
  output logic loopDetectorEnable, // Inband loop code detection on
  output logic autoLoopEnable, // Automatic inband loopback on
  output logic [7:0] activateMask, // Effective activation code bits
  output logic [7:0] deactivateMask, // Effective deactivation code bits
  output logic [7:0] activateCode, // Activation code register
  output logic [7:0] deactivateCode // Deactivation code register
);

  function automatic logic [7:0] lenMask(input logic [1:0] len);
    unique case (len)
      2'h0: lenMask = 8'hf8;
      2'h1: lenMask = 8'hfc;
      2'h2: lenMask = 8'hfe;
      2'h3: lenMask = 8'hff;
    endcase
  endfunction : lenMask

  logic [7:0] bankPtr;
  logic [3:0] singleRail, lineCode, clkRecDis, rxPdn, txPdn, exzEn, cvDis, eqEn;
  logic [5:0] loopCfg;
  logic [7:0] actCode, deactCode;

  wire logic inExp = (bankPtr == BANK_EXPANDED);
  wire logic ptrHit = (addr == OFF_BANK_PTR);
  wire logic expWr = wrEn && inExp && !ptrHit;
  wire logic wrSingle = expWr && addr == OFF_SINGLE_RAIL;
  wire logic wrCode = expWr && addr == OFF_LINE_CODE;
  wire logic wrCrs = expWr && addr == OFF_CLK_REC_DIS;
  wire logic wrRpdn = expWr && addr == OFF_RX_PDN;
  wire logic wrTpdn = expWr && addr == OFF_TX_PDN;
  wire logic wrExz = expWr && addr == OFF_EXZ_EN;
  wire logic wrCv = expWr && addr == OFF_CV_DIS;
  wire logic wrEq = expWr && addr == OFF_EQ_EN;
  wire logic wrCfg = expWr && addr == OFF_LOOP_CFG;
  wire logic wrAct = expWr && addr == OFF_ACT_CODE;
  wire logic wrDeact = expWr && addr == OFF_DEACT_CODE;

  // Upper reserved bits are not stored, so they always read back zero
  logic [7:0] next_rdData;
  always_comb
  begin
    next_rdData = RESET_VALUE;
    if (ptrHit)
      next_rdData = bankPtr;
    else if (inExp)
    begin
      unique case (addr)
        OFF_SINGLE_RAIL: next_rdData = {4'h0, singleRail};
        OFF_LINE_CODE: next_rdData = {4'h0, lineCode};
        OFF_CLK_REC_DIS: next_rdData = {4'h0, clkRecDis};
        OFF_RX_PDN: next_rdData = {4'h0, rxPdn};
        OFF_TX_PDN: next_rdData = {4'h0, txPdn};
        OFF_EXZ_EN: next_rdData = {4'h0, exzEn};
        OFF_CV_DIS: next_rdData = {4'h0, cvDis};
        OFF_EQ_EN: next_rdData = {4'h0, eqEn};
        OFF_LOOP_CFG: next_rdData = {2'h0, loopCfg};
        OFF_ACT_CODE: next_rdData = actCode;
        OFF_DEACT_CODE: next_rdData = deactCode;
        default: next_rdData = RESET_VALUE;
      endcase
    end
  end

  // Pointer lives in both banks so software can always return
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      bankPtr <= RESET_VALUE;
    else if (wrEn && ptrHit)
      bankPtr <= wrData;
  end

  // Per-channel registers keep only bits 3-0, bit n for channel n
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      singleRail <= RESET_VALUE[3:0];
    else if (wrSingle)
      singleRail <= wrData[3:0];
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      lineCode <= RESET_VALUE[3:0];
    else if (wrCode)
      lineCode <= wrData[3:0];
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      clkRecDis <= RESET_VALUE[3:0];
    else if (wrCrs)
      clkRecDis <= wrData[3:0];
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rxPdn <= RESET_VALUE[3:0];
    else if (wrRpdn)
      rxPdn <= wrData[3:0];
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      txPdn <= RESET_VALUE[3:0];
    else if (wrTpdn)
      txPdn <= wrData[3:0];
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      exzEn <= RESET_VALUE[3:0];
    else if (wrExz)
      exzEn <= wrData[3:0];
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cvDis <= RESET_VALUE[3:0];
    else if (wrCv)
      cvDis <= wrData[3:0];
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      eqEn <= RESET_VALUE[3:0];
    else if (wrEq)
      eqEn <= wrData[3:0];
  end

  // One global copy serves all four channels
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      loopCfg <= RESET_VALUE[5:0];
    else if (wrCfg)
      loopCfg <= wrData[5:0] & LCF_MASK[5:0];
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      actCode <= RESET_VALUE;
    else if (wrAct)
      actCode <= wrData;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      deactCode <= RESET_VALUE;
    else if (wrDeact)
      deactCode <= wrData;
  end

  // Effective per-channel modes
  logic [3:0] next_single, next_ami, next_crOn, next_txPdn, next_exz, next_cv;
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++)
    begin : g_ch
      wire logic crOn = !clkRecDis[ch];
      // Forced single rail only holds with recovery on; otherwise pin decides
      assign next_single[ch] = (singleRail[ch] && crOn) || railSelectPin[ch];
      assign next_ami[ch] = singleRail[ch] && crOn && lineCode[ch];
      assign next_crOn[ch] = crOn;
      assign next_txPdn[ch] = txPdn[ch] || !transmitClockPin[ch];
      // Detectors only apply to the B8ZS/HDB3 decoder in single rail
      assign next_exz[ch] = exzEn[ch] && next_single[ch] && !next_ami[ch];
      assign next_cv[ch] = !cvDis[ch] && next_single[ch] && !next_ami[ch];
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdData <= RESET_VALUE;
      rdValid <= 1'b0;
      expandedSel <= 1'b0;
    end
    else
    begin
      rdData <= rdEn ? next_rdData : RESET_VALUE;
      rdValid <= rdEn;
      expandedSel <= inExp;
    end
  end

  // Channel mode outputs
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      singleRailMode <= 4'h0;
      amiSelect <= 4'h0;
      clockRecoveryOn <= CLK_REC_ON_RESET;
    end
    else
    begin
      singleRailMode <= next_single;
      amiSelect <= next_ami;
      clockRecoveryOn <= next_crOn;
    end
  end

  // Drivers float while reset is held, so the line stays quiet until released
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rxPowerDown <= 4'h0;
      txPowerDown <= 4'h0;
      txDriverOe <= 4'h0;
    end
    else
    begin
      rxPowerDown <= rxPdn;
      txPowerDown <= next_txPdn;
      txDriverOe <= ~next_txPdn;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      excessZeroDetect <= 4'h0;
      codeViolationDetect <= 4'h0;
      rxEqualizerOn <= 4'h0;
    end
    else
    begin
      excessZeroDetect <= next_exz;
      codeViolationDetect <= next_cv;
      rxEqualizerOn <= eqEn;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      loopDetectorEnable <= 1'b0;
      autoLoopEnable <= 1'b0;
      activateMask <= CODE_MASK_RESET;
      deactivateMask <= CODE_MASK_RESET;
    end
    else
    begin
      loopDetectorEnable <= loopCfg[LCF_DET_EN];
      autoLoopEnable <= loopCfg[LCF_AUTO_EN];
      activateMask <= lenMask(loopCfg[LCF_ACT_LEN_LSB +: 2]);
      deactivateMask <= lenMask(loopCfg[LCF_DEACT_LEN_LSB +: 2]);
    end
  end

  // Codes are repeated at the outputs for the loop code detector
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      activateCode <= RESET_VALUE;
      deactivateCode <= RESET_VALUE;
    end
    else
    begin
      activateCode <= actCode;
      deactivateCode <= deactCode;
    end
  end

endmodule : elc_bank

// ---- test/elc_host.sv ----
/*
  Host processor model: byte register writes and reads as one-cycle strobes.
  Assumes the bank samples its strobes on the rising edge of clk.
*/
module elc_host (
  input wire logic clk, // Device clock
  output logic wrEn, // Write strobe
  output logic rdEn, // Read strobe
  output logic [7:0] addr, // Register address
  output logic [7:0] wrData, // Write data
  input wire logic [7:0] rdData // Read data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    {wrEn, rdEn, addr, wrData} = '0;
  end
  // Released lines carry the inverse so stale values never look live
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wrEn = 1'b1;
    addr = a;
    wrData = d;
    @(negedge clk);
    wrEn = 1'b0;
    addr = ~a;
    wrData = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    rdEn = 1'b1;
    addr = a;
    @(negedge clk);
    rdEn = 1'b0;
    addr = ~a;
    d = rdData;
  endtask : rd
endmodule : elc_host

// ---- test/elc_bank_sva.sv ----
/*
  Port checker for the line configuration bank.
  Bound to every elc_bank instance; sees only its ports.
*/
module elc_bank_sva (
  input wire logic clk, rst_n, wrEn, rdEn, rdValid, expandedSel, // Bus and status
  input wire logic [7:0] addr, wrData, rdData, activateMask, deactivateMask, // Bytes
  input wire logic [3:0] railSelectPin, transmitClockPin, singleRailMode, amiSelect, // Mode
  input wire logic [3:0] clockRecoveryOn, txPowerDown, txDriverOe, excessZeroDetect, // Chan
  input wire logic [3:0] codeViolationDetect // Detect
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence ptrWr(logic [7:0] v);
    wrEn && addr == 8'h1f && wrData == v;
  endsequence
  read_answer_a: assert property (rdEn |=> rdValid)
    else $error("read strobe not answered");
  bank_on_a: assert property (ptrWr(8'haa) |-> ##[1:2] expandedSel)
    else $error("expanded bank not selected");
  bank_off_a: assert property (ptrWr(8'h00) |-> ##[1:2] !expandedSel)
    else $error("primary bank not restored");
  // Outputs still show their reset values at the first edge after release
  rail_pin_a: assert property ($past(rst_n) |->
    (singleRailMode & $past(railSelectPin)) == $past(railSelectPin))
    else $error("rail pin ignored");
  tx_clock_a: assert property ($past(rst_n) |->
    (txPowerDown & ~$past(transmitClockPin)) == ~$past(transmitClockPin))
    else $error("held transmit clock did not power down");
  tx_highz_a: assert property ($past(rst_n) |-> txDriverOe == ~txPowerDown)
    else $error("driver enabled while powered down");
  ami_mode_a: assert property (
    (amiSelect & ~(singleRailMode & clockRecoveryOn)) == 4'h0)
    else $error("line code chosen outside single rail");
  detect_mode_a: assert property (
    ((excessZeroDetect | codeViolationDetect) & (amiSelect | ~singleRailMode)) == 4'h0)
    else $error("detection outside B8ZS single rail");
  code_mask_a: assert property (
    activateMask inside {8'hf8, 8'hfc, 8'hfe, 8'hff} &&
    deactivateMask inside {8'hf8, 8'hfc, 8'hfe, 8'hff})
    else $error("code mask not top aligned");
endmodule : elc_bank_sva

bind elc_bank elc_bank_sva elc_bank_sva_inst (.*);

// ---- test/tb_elc_bank.sv ----
/*
  Self-checking bench for the line configuration bank.
  Assumes the host model in elc_host and the bound checker.
*/
module tb_elc_bank;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wrEn, rdEn, rdValid, expandedSel, loopDetectorEnable, autoLoopEnable;
  logic [7:0] addr, wrData, rdData, activateMask, deactivateMask, activateCode, deactivateCode;
  logic [3:0] railSelectPin = 4'h0;
  logic [3:0] transmitClockPin = 4'hf;
  logic [3:0] singleRailMode, amiSelect, clockRecoveryOn, rxPowerDown, txPowerDown;
  logic [3:0] txDriverOe, excessZeroDetect, codeViolationDetect, rxEqualizerOn;
  logic [7:0] got;
  int err_count = 0;
  int checked = 0;
  int cyc = 0;
  // Address, write data, readback; reserved upper bits read back zero
  logic [23:0] rows [11] = '{24'h00ff0f, 24'h01ff0f, 24'h02ff0f, 24'h03ff0f, 24'h04ff0f,
    24'h05ff0f, 24'h06ff0f, 24'h07ff0f, 24'h08ff3f, 24'h09c6c6, 24'h0a5a5a};
  always #2 clk = ~clk;
  elc_bank elc_bank_inst (.*);
  elc_host elc_host_inst (.*);
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Write, then wait out the register and output flop stages
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    elc_host_inst.wr(a, d);
    @(negedge clk);
  endtask : w
  task automatic conclude();
    $display("compares %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      err_count++;
      conclude();
    end
  end
  initial
  begin
    repeat (12) @(negedge clk);
    chk("recovery", 4'hf, clockRecoveryOn);
    chk("actMask", 8'hf8, activateMask);
    rst_n = 1'b1;
    w(8'h03, 8'h01);
    w(8'h1f, 8'haa);
    chk("expSel", 1'b1, expandedSel);
    for (int i = 0; i < 11; i++)
    begin
      elc_host_inst.rd(8'(i), got);
      chk("reset", 8'h00, got);
    end
    foreach (rows[i])
    begin
      w(rows[i][23:16], rows[i][15:8]);
      elc_host_inst.rd(rows[i][23:16], got);
      chk("readback", rows[i][7:0], got);
    end
    chk("eq", 4'hf, rxEqualizerOn);
    chk("rxPd", 4'hf, rxPowerDown);
    chk("actCode", 8'hc6, activateCode);
    chk("deactCode", 8'h5a, deactivateCode);
    chk("loopEn", 2'b11, {loopDetectorEnable, autoLoopEnable});
    w(8'h02, 8'h00);
    w(8'h00, 8'h01);
    w(8'h01, 8'h00);
    chk("single", 4'h1, singleRailMode);
    chk("ami", 4'h0, amiSelect);
    chk("exz", 4'h1, excessZeroDetect);
    chk("cv", 4'h0, codeViolationDetect);
    w(8'h06, 8'h00);
    chk("cv", 4'h1, codeViolationDetect);
    w(8'h01, 8'h01);
    chk("ami", 4'h1, amiSelect);
    w(8'h02, 8'h01);
    chk("recov", 4'he, clockRecoveryOn);
    chk("single", 4'h0, singleRailMode);
    railSelectPin = 4'h8;
    @(negedge clk);
    chk("pin", 4'h8, singleRailMode);
    w(8'h04, 8'h00);
    transmitClockPin = 4'hb;
    @(negedge clk);
    chk("txPd", 4'h4, txPowerDown);
    chk("txOe", 4'hb, txDriverOe);
    for (int i = 0; i < 4; i++)
    begin
      w(8'h08, 8'(8'h30 | (i << 2) | (3 - i)));
      chk("actMask", 8'(8'hff << (3 - i)), activateMask);
      chk("deactMask", 8'(8'hff << i), deactivateMask);
    end
    elc_host_inst.rd(8'h0b, got);
    chk("unmapped", 8'h00, got);
    w(8'h1f, 8'h00);
    elc_host_inst.rd(8'h03, got);
    chk("primary", 8'h00, got);
    chk("expSel", 1'b0, expandedSel);
    conclude();
  end
endmodule : tb_elc_bank
